// ---- termio_consts.svh ----
`ifndef TERMIO_CONSTS_SVH
`define TERMIO_CONSTS_SVH

// Memory map, decoded on the top address nibble
`define DISP_NIBBLE 4'h3
`define NVM_NIBBLE 4'h6
`define PRN_NIBBLE 4'h7

// Field positions in the display write address
`define DISP_SEG_BIT 4
`define LAMP_SEL_MSB 3
`define LAMP_SEL_LSB 1
`define LAMP_VAL_BIT 0

// Non-volatile port fields
`define NVM_CTL_MSB 10
`define NVM_CTL_LSB 8
`define NVM_CLK_BIT 0
`define NVM_DATA_BIT 7
`define NVM_WORDS 100
`define NVM_WIDTH 14
`define NVM_AW 7
`define NVM_ADDR_BITS 20

// Wait states inserted per access
`define NVM_WAITS 1
`define PRN_WAITS 1

// I/O port decode
`define IO_HI_BIT 7
`define IO_UTIL_BIT 1

// Utility port bits
`define UT_CTS 0
`define UT_RING 1
`define UT_OPT_N 2
`define UT_LOOPGATE 3
`define UT_SEC_CD 6
`define UT_CD 7
`define UO_DTR 0
`define UO_LOOP 3
`define UO_BAUD64 6
`define UO_EXTRST 7
`define UO_RESET 8'h00

// Restart vectors
`define VEC_DOT_TICK 3'h1
`define VEC_TICK 3'h3
`define VEC_DOT 3'h5
`define VEC_RX 3'h7

`endif

// ---- termio_pkg.sv ----
package termio_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } bus_state_t;

  typedef enum logic [2:0] {
    NV_STANDBY = 3'h0,
    NV_READ = 3'h1,
    NV_ERASE = 3'h2,
    NV_WRITE = 3'h3,
    NV_UNUSED = 3'h4,
    NV_SHIFT_OUT = 3'h5,
    NV_ADDR_IN = 3'h6,
    NV_DATA_IN = 3'h7
  } nvm_cmd_t;

endpackage

// ---- nvm_array.sv ----
`timescale 1ns/1ps
`include "termio_consts.svh"

module nvm_array #(
  parameter int WORDS = `NVM_WORDS,
  parameter int WIDTH = `NVM_WIDTH,
  parameter int AW = `NVM_AW
) (
  // Clock
  input wire logic clk_i,
  // Access
  input wire logic wr_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [WORDS];
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;
  logic in_range;

  always_comb begin
    in_range = (32'(addr_i) < WORDS);
    nxt_rdata = in_range ? mem[addr_i] : '0;
  end

  // Out-of-range addresses drop writes and read zero
  always_ff @(posedge clk_i) begin
    if (wr_i && in_range) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_ff <= nxt_rdata;
  end

  assign rdata_o = rdata_ff;

endmodule // nvm_array

// ---- nvm_serial.sv ----
`timescale 1ns/1ps
`include "termio_consts.svh"

module nvm_serial
  import termio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bit-banged port, one step per memory clock rising edge
  input wire logic step_i,
  input wire logic [2:0] cmd_i,
  input wire logic din_i,
  output logic dout_o,
  // Word store
  input wire logic [`NVM_WIDTH-1:0] rdata_i,
  output logic wr_o,
  output logic [`NVM_AW-1:0] addr_o,
  output logic [`NVM_WIDTH-1:0] wdata_o
);

  logic [`NVM_ADDR_BITS-1:0] addr_sh_ff, nxt_addr_sh;
  logic [`NVM_WIDTH-1:0] data_ff, nxt_data;
  logic wr_ff, nxt_wr;

  // 1-of-10 code to decimal digit; 15 flags a bad code
  function automatic logic [3:0] hot_to_num(input logic [9:0] code);
    logic [3:0] r;
    r = 4'hF;
    for (int i = 0; i < 10; i++) begin
      if (code == (10'h001 << i)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [3:0] row, col;

  always_comb begin
    row = hot_to_num(addr_sh_ff[19:10]);
    col = hot_to_num(addr_sh_ff[9:0]);
    // Widen before the product, a 4-bit product would alias words
    addr_o = (row > 4'h9 || col > 4'h9) ? 7'h7F :
      7'(row) * 7'h0A + 7'(col);
    nxt_addr_sh = addr_sh_ff;
    nxt_data = data_ff;
    nxt_wr = 1'b0;
    if (step_i) begin
      case (nvm_cmd_t'(cmd_i))
        NV_ADDR_IN: nxt_addr_sh = {addr_sh_ff[18:0], din_i};
        NV_DATA_IN: nxt_data = {data_ff[12:0], din_i};
        NV_READ: nxt_data = rdata_i;
        NV_ERASE: begin
          nxt_data = '0;
          nxt_wr = 1'b1;
        end
        NV_WRITE: nxt_wr = 1'b1;
        NV_SHIFT_OUT: nxt_data = {data_ff[12:0], 1'b0};
        default: nxt_data = data_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      addr_sh_ff <= '0;
      data_ff <= '0;
      wr_ff <= 1'b0;
    end else begin
      addr_sh_ff <= nxt_addr_sh;
      data_ff <= nxt_data;
      wr_ff <= nxt_wr;
    end
  end

  assign wr_o = wr_ff;
  assign wdata_o = data_ff;
  assign dout_o = data_ff[`NVM_WIDTH-1];

endmodule // nvm_serial

// ---- terminal_io.sv ----
// Operation
// - Memory writes 3000H-3FFFH reach display; A5-A11 and data ignored.
// - A4 low: A3..A1 pick lamp latch, A0 gives its new state.
// - Every lamp write returns digit counter to zero.
// - A4 high: count up, load segments, light counted digit.
// - Counts 1..4 pick ones..thousands; others none; 15 wraps to 0.
// - Digit data on A0-A3 inverted BCD; 0000 blanks.
// - Selected digit held until next count, lamp write or reset; segments until next count or reset.
// - 6xxxH selects non-volatile port with exactly one wait state.
// - A8-A10 drive control lines, A0 memory clock, D7 serial data.
// - Control codes: standby, read, erase, write, shift out, address, data.
// - Store holds 100 words of 14 bits, moved bit-serially.
// - 7xxxH selects printer controller, one wait; A0-A1 unused on reads.
// - I/O 0xxxxx0x selects serial controller; A0 data or control.
// - Receive character available requests interrupt, vector 7 alone.
// - I/O 0xxxxx1x selects utility ports; outputs cleared at reset.
// - Utility input: CTS, ring, option_n, loop gate, sec CD, CD.
// - Utility output: terminal ready, loopback, baud divisor, ext reset.
// - Loopback joins serial transmit to receive, detached from line.
// - Reads in 3000H-3FFFH go to keyboard, never to the display.
`timescale 1ns/1ps
`include "termio_consts.svh"

module terminal_io
  import termio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Processor bus, one-cycle request strobes
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ack_o,
  output logic kbd_sel_o,
  // Interrupt
  output logic int_req_o,
  output logic [2:0] int_vec_o,
  // Lamps and numeric display
  output logic [7:0] lamp_o,
  output logic [3:0] digit_o,
  output logic [6:0] seg_o,
  // Non-volatile port lines
  output logic [2:0] nvm_ctl_o,
  output logic nvm_clk_o,
  // Printer controller
  output logic prn_sel_o,
  output logic prn_rd_o,
  output logic prn_wr_o,
  output logic [1:0] prn_a_o,
  output logic [7:0] prn_wdata_o,
  input wire logic [7:0] prn_rdata_i,
  input wire logic prn_dot_irq_i,
  input wire logic prn_tick_irq_i,
  // Serial controller
  output logic scc_sel_o,
  output logic scc_rd_o,
  output logic scc_wr_o,
  output logic scc_a0_o,
  output logic [7:0] scc_wdata_o,
  input wire logic [7:0] scc_rdata_i,
  input wire logic rx_char_available_i,
  input wire logic scc_txd_i,
  output logic scc_rxd_o,
  // Modem line pins
  input wire logic ext_rxd_i,
  output logic ext_txd_o,
  input wire logic cts_i,
  input wire logic ring_i,
  input wire logic option_n_i,
  input wire logic sec_cd_i,
  input wire logic cd_i,
  output logic dtr_o,
  output logic baud64_o,
  output logic ext_reset_o
);

  // Inverted BCD to segments {g,f,e,d,c,b,a}; codes above nine blank
  function automatic logic [6:0] seg_of(input logic [3:0] code);
    logic [6:0] s;
    case (~code)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      default: s = 7'h00;
    endcase
    return s;
  endfunction

  // Pin synchronisers
  logic [5:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      // Receive pin idles high: no false start bit after reset
      pin_s1_ff <= 6'h20;
      pin_s2_ff <= 6'h20;
    end else begin
      pin_s1_ff <= {ext_rxd_i, cd_i, sec_cd_i, option_n_i, ring_i, cts_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Request decode
  logic any_req, mem_req, io_req, wr_req;
  logic hit_disp, hit_kbd, hit_nvm, hit_prn, hit_scc, hit_util;
  logic need_wait;
  always_comb begin
    mem_req = mem_rd_i | mem_wr_i;
    io_req = io_rd_i | io_wr_i;
    any_req = mem_req | io_req;
    wr_req = mem_wr_i | io_wr_i;
    hit_disp = mem_wr_i && addr_i[15:12] == `DISP_NIBBLE;
    hit_kbd = mem_rd_i && addr_i[15:12] == `DISP_NIBBLE;
    hit_nvm = mem_req && addr_i[15:12] == `NVM_NIBBLE;
    hit_prn = mem_req && addr_i[15:12] == `PRN_NIBBLE;
    hit_scc = io_req && !addr_i[`IO_HI_BIT] && !addr_i[`IO_UTIL_BIT];
    hit_util = io_req && !addr_i[`IO_HI_BIT] && addr_i[`IO_UTIL_BIT];
    need_wait = hit_nvm || hit_prn;
  end

  // Bus sequencer
  bus_state_t state_ff, nxt_state;
  logic is_rd_ff, nxt_is_rd;
  logic sel_nvm_ff, nxt_sel_nvm;
  logic ack_ff, nxt_ack;
  logic [7:0] rdata_ff, nxt_rdata;
  logic oe_ff, nxt_oe;
  logic kbd_ff, nxt_kbd;
  logic prn_sel_ff, nxt_prn_sel, prn_rd_ff, nxt_prn_rd, prn_wr_ff, nxt_prn_wr;
  logic scc_sel_ff, nxt_scc_sel, scc_rd_ff, nxt_scc_rd, scc_wr_ff, nxt_scc_wr;
  logic util_ff, nxt_util;
  logic [1:0] prn_a_ff, nxt_prn_a;
  logic scc_a0_ff, nxt_scc_a0;
  logic [7:0] wdata_ff, nxt_wdata;
  logic nvm_dout;
  logic [7:0] util_in;
  logic [7:0] util_out_ff, nxt_util_out;

  always_comb begin
    util_in = 8'h00;
    util_in[`UT_CTS] = pin_s2_ff[0];
    util_in[`UT_RING] = pin_s2_ff[1];
    util_in[`UT_OPT_N] = pin_s2_ff[2];
    util_in[`UT_LOOPGATE] = util_out_ff[`UO_LOOP];
    util_in[`UT_SEC_CD] = pin_s2_ff[3];
    util_in[`UT_CD] = pin_s2_ff[4];
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_is_rd = is_rd_ff;
    nxt_sel_nvm = sel_nvm_ff;
    nxt_ack = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_oe = 1'b0;
    nxt_kbd = kbd_ff;
    nxt_prn_sel = prn_sel_ff;
    nxt_prn_rd = prn_rd_ff;
    nxt_prn_wr = prn_wr_ff;
    nxt_scc_sel = scc_sel_ff;
    nxt_scc_rd = scc_rd_ff;
    nxt_scc_wr = scc_wr_ff;
    nxt_util = util_ff;
    nxt_prn_a = prn_a_ff;
    nxt_scc_a0 = scc_a0_ff;
    nxt_wdata = wdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (any_req) begin
          nxt_state = need_wait ? ST_WAIT : ST_DONE;
          nxt_is_rd = mem_rd_i | io_rd_i;
          nxt_sel_nvm = hit_nvm;
          nxt_kbd = hit_kbd;
          nxt_prn_sel = hit_prn;
          nxt_prn_rd = hit_prn && mem_rd_i;
          nxt_prn_wr = hit_prn && mem_wr_i;
          // low address bits only on writes
          nxt_prn_a = mem_wr_i ? addr_i[1:0] : 2'h0;
          nxt_scc_sel = hit_scc;
          nxt_scc_rd = hit_scc && io_rd_i;
          nxt_scc_wr = hit_scc && io_wr_i;
          nxt_scc_a0 = addr_i[0];
          nxt_util = hit_util;
          nxt_wdata = wr_req ? data_i : wdata_ff;
        end
      end
      ST_WAIT: nxt_state = ST_DONE;
      ST_DONE: begin
        nxt_state = ST_IDLE;
        nxt_ack = 1'b1;
        nxt_oe = is_rd_ff;
        if (!is_rd_ff) begin
          nxt_rdata = 8'h00;
        end else if (prn_sel_ff) begin
          nxt_rdata = prn_rdata_i;
        end else if (scc_sel_ff) begin
          nxt_rdata = scc_rdata_i;
        end else if (util_ff) begin
          nxt_rdata = util_in;
        end else if (sel_nvm_ff) begin
          nxt_rdata = {nvm_dout, 7'h00};
        end else begin
          nxt_rdata = 8'h00;
        end
        nxt_kbd = 1'b0;
        nxt_prn_sel = 1'b0;
        nxt_prn_rd = 1'b0;
        nxt_prn_wr = 1'b0;
        nxt_scc_sel = 1'b0;
        nxt_scc_rd = 1'b0;
        nxt_scc_wr = 1'b0;
        nxt_util = 1'b0;
        nxt_sel_nvm = 1'b0;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      is_rd_ff <= 1'b0;
      sel_nvm_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      oe_ff <= 1'b0;
      kbd_ff <= 1'b0;
      prn_sel_ff <= 1'b0;
      prn_rd_ff <= 1'b0;
      prn_wr_ff <= 1'b0;
      scc_sel_ff <= 1'b0;
      scc_rd_ff <= 1'b0;
      scc_wr_ff <= 1'b0;
      util_ff <= 1'b0;
      prn_a_ff <= 2'h0;
      scc_a0_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      is_rd_ff <= nxt_is_rd;
      sel_nvm_ff <= nxt_sel_nvm;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      oe_ff <= nxt_oe;
      kbd_ff <= nxt_kbd;
      prn_sel_ff <= nxt_prn_sel;
      prn_rd_ff <= nxt_prn_rd;
      prn_wr_ff <= nxt_prn_wr;
      scc_sel_ff <= nxt_scc_sel;
      scc_rd_ff <= nxt_scc_rd;
      scc_wr_ff <= nxt_scc_wr;
      util_ff <= nxt_util;
      prn_a_ff <= nxt_prn_a;
      scc_a0_ff <= nxt_scc_a0;
      wdata_ff <= nxt_wdata;
    end
  end

  // Display, utility outputs, store port and serial lines
  logic take;
  logic [7:0] lamp_ff, nxt_lamp;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] digit_ff, nxt_digit;
  logic [6:0] seg_ff, nxt_seg;
  logic [2:0] nvm_ctl_ff, nxt_nvm_ctl;
  logic nvm_clk_ff, nxt_nvm_clk;
  logic nvm_step;
  logic int_ff, nxt_int;
  logic [2:0] vec_ff, nxt_vec;
  logic txd_ff, nxt_txd, rxd_ff, nxt_rxd;

  always_comb begin
    take = any_req && state_ff == ST_IDLE;
    nxt_lamp = lamp_ff;
    nxt_cnt = cnt_ff;
    nxt_digit = digit_ff;
    nxt_seg = seg_ff;
    if (take && hit_disp) begin
      if (!addr_i[`DISP_SEG_BIT]) begin
        nxt_lamp[addr_i[`LAMP_SEL_MSB:`LAMP_SEL_LSB]] = addr_i[`LAMP_VAL_BIT];
        nxt_cnt = 4'h0;
        nxt_digit = 4'h0;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
        nxt_digit = (nxt_cnt >= 4'h1 && nxt_cnt <= 4'h4) ?
          4'(4'h1 << (nxt_cnt - 4'h1)) : 4'h0;
        nxt_seg = seg_of(addr_i[3:0]);
      end
    end
    nxt_util_out = (take && hit_util && io_wr_i) ? data_i : util_out_ff;
    nxt_nvm_ctl = nvm_ctl_ff;
    nxt_nvm_clk = nvm_clk_ff;
    if (take && hit_nvm) begin
      nxt_nvm_ctl = addr_i[`NVM_CTL_MSB:`NVM_CTL_LSB];
      nxt_nvm_clk = addr_i[`NVM_CLK_BIT];
    end
    // engine acts on clock rising edge
    nvm_step = take && hit_nvm && addr_i[`NVM_CLK_BIT] && !nvm_clk_ff;
    nxt_int = prn_dot_irq_i | prn_tick_irq_i | rx_char_available_i;
    case ({prn_dot_irq_i, rx_char_available_i, prn_tick_irq_i})
      3'b001: nxt_vec = `VEC_TICK;
      3'b010: nxt_vec = `VEC_RX;
      3'b011: nxt_vec = `VEC_TICK;
      3'b100: nxt_vec = `VEC_DOT;
      3'b101: nxt_vec = `VEC_DOT_TICK;
      3'b110: nxt_vec = `VEC_TICK;
      3'b111: nxt_vec = `VEC_DOT_TICK;
      default: nxt_vec = 3'h0;
    endcase
    nxt_txd = util_out_ff[`UO_LOOP] ? 1'b1 : scc_txd_i;
    nxt_rxd = util_out_ff[`UO_LOOP] ? scc_txd_i : pin_s2_ff[5];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lamp_ff <= 8'h00;
      cnt_ff <= 4'h0;
      digit_ff <= 4'h0;
      seg_ff <= 7'h00;
      util_out_ff <= `UO_RESET;
      nvm_ctl_ff <= 3'h0;
      nvm_clk_ff <= 1'b0;
      int_ff <= 1'b0;
      vec_ff <= 3'h0;
      txd_ff <= 1'b1;
      rxd_ff <= 1'b1;
    end else begin
      lamp_ff <= nxt_lamp;
      cnt_ff <= nxt_cnt;
      digit_ff <= nxt_digit;
      seg_ff <= nxt_seg;
      util_out_ff <= nxt_util_out;
      nvm_ctl_ff <= nxt_nvm_ctl;
      nvm_clk_ff <= nxt_nvm_clk;
      int_ff <= nxt_int;
      vec_ff <= nxt_vec;
      txd_ff <= nxt_txd;
      rxd_ff <= nxt_rxd;
    end
  end

  logic nv_wr;
  logic [`NVM_AW-1:0] nv_addr;
  logic [`NVM_WIDTH-1:0] nv_wdata, nv_rdata;

  nvm_serial u_engine (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .step_i(nvm_step),
    .cmd_i(addr_i[`NVM_CTL_MSB:`NVM_CTL_LSB]),
    .din_i(data_i[`NVM_DATA_BIT]),
    .dout_o(nvm_dout),
    .rdata_i(nv_rdata),
    .wr_o(nv_wr),
    .addr_o(nv_addr),
    .wdata_o(nv_wdata)
  );

  nvm_array #(
    .WORDS(`NVM_WORDS),
    .WIDTH(`NVM_WIDTH),
    .AW(`NVM_AW)
  ) u_store (
    .clk_i(clk_i),
    .wr_i(nv_wr),
    .addr_i(nv_addr),
    .wdata_i(nv_wdata),
    .rdata_o(nv_rdata)
  );

  assign data_o = rdata_ff;
  assign data_oe_o = oe_ff;
  assign ack_o = ack_ff;
  assign kbd_sel_o = kbd_ff;
  assign int_req_o = int_ff;
  assign int_vec_o = vec_ff;
  assign lamp_o = lamp_ff;
  assign digit_o = digit_ff;
  assign seg_o = seg_ff;
  assign nvm_ctl_o = nvm_ctl_ff;
  assign nvm_clk_o = nvm_clk_ff;
  assign prn_sel_o = prn_sel_ff;
  assign prn_rd_o = prn_rd_ff;
  assign prn_wr_o = prn_wr_ff;
  assign prn_a_o = prn_a_ff;
  assign prn_wdata_o = wdata_ff;
  assign scc_sel_o = scc_sel_ff;
  assign scc_rd_o = scc_rd_ff;
  assign scc_wr_o = scc_wr_ff;
  assign scc_a0_o = scc_a0_ff;
  assign scc_wdata_o = wdata_ff;
  assign scc_rxd_o = rxd_ff;
  assign ext_txd_o = txd_ff;
  assign dtr_o = util_out_ff[`UO_DTR];
  assign baud64_o = util_out_ff[`UO_BAUD64];
  assign ext_reset_o = util_out_ff[`UO_EXTRST];

endmodule // terminal_io

// ---- term_chk_sva.sv ----
`timescale 1ns/1ps

module term_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Processor bus
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [15:0] addr_i,
  input wire logic ack_o,
  input wire logic data_oe_o,
  input wire logic kbd_sel_o,
  // Interrupt
  input wire logic int_req_o,
  input wire logic prn_dot_irq_i,
  input wire logic prn_tick_irq_i,
  input wire logic rx_char_available_i,
  // Outputs watched
  input wire logic [7:0] lamp_o,
  input wire logic [3:0] digit_o,
  input wire logic prn_sel_o,
  input wire logic scc_sel_o,
  input wire logic dtr_o,
  input wire logic baud64_o,
  input wire logic ext_reset_o
);
  logic busy_ff;
  logic nxt_busy;
  logic take;
  logic mem_take;
  logic disp_wr;

  // A strobe in the ack cycle is taken, the sequencer is idle again
  assign take = (mem_rd_i | mem_wr_i | io_rd_i | io_wr_i) & (~busy_ff | ack_o);
  assign mem_take = take & (mem_rd_i | mem_wr_i);
  assign disp_wr = take & mem_wr_i & (addr_i[15:12] == 4'h3);

  always_comb begin
    nxt_busy = busy_ff;
    if (take) begin
      nxt_busy = 1'b1;
    end else if (ack_o) begin
      nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_plain;
    ##1 !ack_o ##1 ack_o;
  endsequence
  sequence s_wait;
    ##1 !ack_o ##1 !ack_o ##1 ack_o;
  endsequence

  property p_disp_ack;
    disp_wr |-> s_plain;
  endproperty
  a_disp_ack: assert property (p_disp_ack)
    else $error("display write ack timing wrong");

  property p_lamp;
    disp_wr && !addr_i[4] |=>
      lamp_o[$past(addr_i[3:1])] == $past(addr_i[0]) && digit_o == 4'h0;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp latch or digit counter wrong");

  property p_digit_sel;
    1'b1 |-> $onehot0(digit_o);
  endproperty
  a_digit_sel: assert property (p_digit_sel)
    else $error("more than one digit lit");

  property p_digit_hold;
    $changed(digit_o) && $past(nrst_i) |-> $past(disp_wr);
  endproperty
  a_digit_hold: assert property (p_digit_hold)
    else $error("digit changed without a display write");

  property p_nvm_wait;
    mem_take && addr_i[15:12] == 4'h6 |-> s_wait;
  endproperty
  a_nvm_wait: assert property (p_nvm_wait)
    else $error("store access wait state wrong");

  property p_prn_wait;
    mem_take && addr_i[15:12] == 4'h7 |->
      ##1 prn_sel_o [*2] ##1 (ack_o && !prn_sel_o);
  endproperty
  a_prn_wait: assert property (p_prn_wait)
    else $error("printer access select or wait wrong");

  property p_scc_sel;
    take && (io_rd_i | io_wr_i) && !addr_i[7] && !addr_i[1] |=> scc_sel_o;
  endproperty
  a_scc_sel: assert property (p_scc_sel)
    else $error("serial controller not selected");

  property p_int;
    $past(nrst_i) |->
      int_req_o == $past(prn_dot_irq_i | prn_tick_irq_i | rx_char_available_i);
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt request does not follow sources");

  property p_util_rst;
    $rose(nrst_i) |-> !dtr_o && !baud64_o && !ext_reset_o;
  endproperty
  a_util_rst: assert property (p_util_rst)
    else $error("utility outputs not cleared by reset");

  property p_kbd;
    mem_take && mem_rd_i && addr_i[15:12] == 4'h3 |=>
      kbd_sel_o && $stable(digit_o);
  endproperty
  a_kbd: assert property (p_kbd)
    else $error("keyboard read touched the display");

  property p_oe;
    data_oe_o |-> ack_o ##1 !ack_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("read drive outside a one-cycle ack");
endmodule // term_chk

bind terminal_io term_chk term_chk_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
  .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .addr_i(addr_i), .ack_o(ack_o),
  .data_oe_o(data_oe_o), .kbd_sel_o(kbd_sel_o), .int_req_o(int_req_o),
  .prn_dot_irq_i(prn_dot_irq_i), .prn_tick_irq_i(prn_tick_irq_i),
  .rx_char_available_i(rx_char_available_i), .lamp_o(lamp_o),
  .digit_o(digit_o), .prn_sel_o(prn_sel_o), .scc_sel_o(scc_sel_o),
  .dtr_o(dtr_o), .baud64_o(baud64_o), .ext_reset_o(ext_reset_o)
);

// ---- periph_model.sv ----
`timescale 1ns/1ps

module periph_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Test control: dot, receive set, tick
  input wire logic [2:0] irq_cfg_i,
  // Selects from the block
  input wire logic prn_sel_i,
  input wire logic scc_sel_i,
  input wire logic scc_rd_i,
  input wire logic scc_a0_i,
  // Answers
  output logic [7:0] prn_rdata_o,
  output logic [7:0] scc_rdata_o,
  output logic dot_o,
  output logic tick_o,
  output logic rx_o
);
  // Unselected buses show the inverse, never a stale match
  assign prn_rdata_o = prn_sel_i ? 8'hA7 : 8'h58;
  assign scc_rdata_o = scc_sel_i ? 8'h3C : 8'hC3;
  assign dot_o = irq_cfg_i[2];
  assign tick_o = irq_cfg_i[0];

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_o <= 1'b0;
    end else if (irq_cfg_i[1]) begin
      rx_o <= 1'b1;
    end else if (scc_sel_i && scc_rd_i && !scc_a0_i) begin
      rx_o <= 1'b0;
    end
  end
endmodule // periph_model

// ---- tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic mem_rd_i = 1'b0, mem_wr_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] data_i = 8'h00;
  logic scc_txd_i = 1'b1, ext_rxd_i = 1'b1, cts_i = 1'b1, ring_i = 1'b0;
  logic option_n_i = 1'b1, sec_cd_i = 1'b1, cd_i = 1'b0;
  logic [2:0] irq_cfg = 3'h0;
  logic [7:0] data_o, lamp_o, prn_rdata, scc_rdata, q;
  logic [3:0] digit_o;
  logic [6:0] seg_o;
  logic [2:0] nvm_ctl_o, int_vec_o;
  logic ack_o, int_req_o, dtr_o, baud64_o, ext_reset_o, ext_txd_o, scc_rxd_o;
  logic prn_sel_o, scc_sel_o, scc_rd_o, scc_a0_o, dot, tick, rx, nvm_clk_o;
  int n_fail = 0;
  int compares = 0;
  int i, r, c;
  localparam logic [6:0] SEG[10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
                                     7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  localparam logic [2:0] VEC[8] = '{3'h0, 3'h3, 3'h7, 3'h3,
                                    3'h5, 3'h1, 3'h3, 3'h1};
  localparam logic [13:0] WORD = 14'h2A5C;

  terminal_io terminal_io_inst (
    .clk_i, .nrst_i, .mem_rd_i, .mem_wr_i, .io_rd_i, .io_wr_i, .addr_i,
    .data_i, .data_o, .data_oe_o(), .ack_o, .kbd_sel_o(), .int_req_o,
    .int_vec_o, .lamp_o, .digit_o, .seg_o, .nvm_ctl_o, .nvm_clk_o,
    .prn_sel_o, .prn_rd_o(), .prn_wr_o(), .prn_a_o(), .prn_wdata_o(),
    .prn_rdata_i(prn_rdata), .prn_dot_irq_i(dot), .prn_tick_irq_i(tick),
    .scc_sel_o, .scc_rd_o, .scc_wr_o(), .scc_a0_o, .scc_wdata_o(),
    .scc_rdata_i(scc_rdata), .rx_char_available_i(rx), .scc_txd_i,
    .scc_rxd_o, .ext_rxd_i, .ext_txd_o, .cts_i, .ring_i, .option_n_i,
    .sec_cd_i, .cd_i, .dtr_o, .baud64_o, .ext_reset_o
  );

  periph_model periph_model_inst (
    .clk_i, .nrst_i, .irq_cfg_i(irq_cfg), .prn_sel_i(prn_sel_o),
    .scc_sel_i(scc_sel_o), .scc_rd_i(scc_rd_o), .scc_a0_i(scc_a0_o),
    .prn_rdata_o(prn_rdata), .scc_rdata_o(scc_rdata), .dot_o(dot),
    .tick_o(tick), .rx_o(rx)
  );

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Kind 0 mem read, 1 mem write, 2 io read, 3 io write
  task automatic acc(input int k, input logic [15:0] a, input logic [7:0] d,
                     input int lat);
    int n;
    @(posedge clk_i);
    addr_i <= a;
    data_i <= d;
    mem_rd_i <= (k == 0);
    mem_wr_i <= (k == 1);
    io_rd_i <= (k == 2);
    io_wr_i <= (k == 3);
    @(posedge clk_i);
    {mem_rd_i, mem_wr_i, io_rd_i, io_wr_i} <= 4'h0;
    n = 1;
    @(negedge clk_i);
    while (ack_o !== 1'b1 && n < 9) begin
      n++;
      @(negedge clk_i);
    end
    q = data_o;
    chk(16'(n), 16'(lat));
  endtask

  // One store step: memory clock low then high
  // stepped fast; the logic store has no rate floor
  task automatic nv(input logic [2:0] ct, input logic b);
    acc(1, {5'h0C, ct, 8'h00}, {b, 7'h00}, 3);
    acc(1, {5'h0C, ct, 8'h01}, {b, 7'h00}, 3);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk({lamp_o, digit_o, 1'b0, dtr_o, baud64_o, ext_reset_o}, 16'h0000);
    for (i = 0; i < 8; i++) acc(1, 16'h3FE1 | 16'(i << 1), 8'hFF, 2);
    chk(lamp_o, 8'hFF);
    acc(1, 16'h300A, 8'h00, 2);
    chk(lamp_o, 8'hDF);
    for (i = 1; i <= 17; i++) begin
      acc(1, 16'h3010 | ((i == 16) ? 16'h0 : 16'(~(i % 10) & 15)), 8'h00, 2);
      c = i % 16;
      chk(digit_o, (c >= 1 && c <= 4) ? 4'(1 << (c - 1)) : 4'h0);
      chk(seg_o, (i == 16) ? 7'h00 : SEG[i % 10]);
    end
    acc(0, 16'h3008, 8'h00, 2);
    chk({digit_o, seg_o}, {4'h1, 7'h07});
    acc(1, 16'h3001, 8'h00, 2);
    chk({lamp_o, digit_o, seg_o}, {8'hDF, 4'h0, 7'h07});
    $display("test display done");
    for (r = 0; r < 2; r++) begin
      // Word 47: row code for tens 4, then column code for units 7
      for (i = 0; i < 20; i++) nv(3'h6, (i < 10) ? (i == 5) : (i == 12));
      chk({nvm_ctl_o, nvm_clk_o}, 4'hD);
      if (r == 0) begin
        for (i = 13; i >= 0; i--) nv(3'h7, WORD[i]);
        nv(3'h3, 1'b0);
      end else begin
        nv(3'h2, 1'b0);
      end
      nv(3'h1, 1'b0);
      for (i = 13; i >= 0; i--) begin
        acc(0, 16'h6500, 8'h00, 3);
        chk(q, {(r == 0) ? WORD[i] : 1'b0, 7'h00});
        nv(3'h5, 1'b0);
      end
    end
    nv(3'h0, 1'b0);
    chk({nvm_ctl_o, nvm_clk_o}, 4'h1);
    $display("test store done");
    // Printer writes keep 7 us apart, 280 cycles at this clock
    wait_n(300);
    acc(1, 16'h7FFE, 8'h5A, 3);
    acc(0, 16'h7003, 8'h00, 3);
    chk(q, 8'hA7);
    $display("test printer done");
    // Receive flag stays set until read, so its cases come last
    for (i = 0; i < 8; i++) begin
      c = 32'({i[1], i[2], i[0]});
      @(posedge clk_i);
      irq_cfg <= 3'(c);
      wait_n(4);
      chk({int_req_o, int_vec_o}, {c != 0, VEC[c]});
    end
    @(posedge clk_i);
    irq_cfg <= 3'h0;
    acc(3, 16'h0001, 8'h40, 2);
    wait_n(2);
    chk(int_req_o, 1'b1);
    acc(2, 16'h0000, 8'h00, 2);
    chk(q, 8'h3C);
    wait_n(3);
    chk(int_req_o, 1'b0);
    $display("test serial done");
    acc(3, 16'h0002, 8'hC9, 2);
    chk({dtr_o, baud64_o, ext_reset_o}, 3'h7);
    @(posedge clk_i);
    scc_txd_i <= 1'b0;
    wait_n(5);
    chk({ext_txd_o, scc_rxd_o}, 2'b10);
    acc(2, 16'h0002, 8'h00, 2);
    chk(q, 8'h4D);
    acc(3, 16'h0002, 8'h00, 2);
    wait_n(5);
    chk({ext_txd_o, scc_rxd_o, dtr_o, baud64_o, ext_reset_o}, 5'h08);
    @(posedge clk_i);
    {cts_i, ring_i, sec_cd_i, cd_i} <= 4'b0101;
    acc(2, 16'h0002, 8'h00, 2);
    chk(q, 8'h86);
    acc(2, 16'h0080, 8'h00, 2);
    chk(q, 8'h00);
    acc(0, 16'h4000, 8'h00, 2);
    chk(q, 8'h00);
    $display("test utility done");
    end_sim();
  end
endmodule // tb_top
